// ===== hdl/rsft_pkg.sv
/*
 * Constants and state layout for the receive frame skip timing block.
 * Assumes one clock domain and synchronous, one-cycle input pulses.
 */
// Behaviour
// - Skip sets search flag, next master pulse clears
// - Frame trigger passes one 384k pulse in 48
// - One frame trigger every 125 us
// - Window built from 192k, 96k, 8k, 48k phases
// - Frame phase AND 48k gives 10.4 us gate
// - Gate AND 192k AND 96k gives 2.6 us window
// - Shaped 384k pulse passes only inside window
// - 10.4 us gate is driven out as address gate
// - Skip flag blanks next master pulse
// - Next master pulse clears skip flag
// - Each blanked pulse delays timing one master period
// - Out of frame withholds master train from divider
// - Master train halved into complementary 576k waves
// - 384k toggle fed by gated feedback AND
package rsft_pkg;
  // Master period, 1/1152 kHz, in ns; a blanked pulse slips timing by this
  localparam int MASTER_PERIOD_NS = 868;
  localparam int CORE_PERIOD_PS = 4000;
  localparam int FRAME_PERIOD_NS = 125000;
  // Master pulses per 384k cycle, minus one
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [1:0] DIV3_RISE = 2'h0;
  // 48k cycles per 8k frame, minus one
  localparam logic [2:0] FRAME_LAST = 3'h5;
  localparam logic [2:0] FRAME_HIGH = 3'h0;
  localparam int PULSES_PER_FRAME = 48;

  typedef struct packed {
    logic sq576;
    logic [1:0] div3;
    logic clk384;
    logic phase_192k;
    logic phase_96k;
    logic phase_48k;
    logic [2:0] frame_cnt;
    logic rise384;
    logic pass_hit;
  } rsft_div_s;

  localparam rsft_div_s DIV_RESET = '0;
endpackage : rsft_pkg

// ===== hdl/rsft_timing_if.sv
/*
 * Carrier between the skip control and the divider chain.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface rsft_timing_if;
  logic clk_en;
  logic master_gated;
  logic sq576;
  logic clk384;
  logic rise384;
  logic pass_hit;
  logic phase_192k;
  logic phase_96k;
  logic phase_48k;
  logic frame_phase_8k;

  modport divider (
    input clk_en, master_gated,
    output sq576, clk384, rise384, pass_hit, phase_192k, phase_96k, phase_48k,
    output frame_phase_8k
  );
  modport control (
    output clk_en, master_gated,
    input sq576, clk384, rise384, pass_hit, phase_192k, phase_96k, phase_48k,
    input frame_phase_8k
  );
endinterface : rsft_timing_if

// ===== hdl/rsft_divider.sv
/*
 * Divider chain: gated master pulses in, 576k down to 8k phases out.
 * Assumes master_gated is a one-cycle pulse already qualified by skip logic.
 */
`timescale 1ns/1ps
module rsft_divider (
  input wire logic core_clk,
  input wire logic rstn,
  rsft_timing_if.divider tif
);
  import rsft_pkg::*;

  rsft_div_s st;
  rsft_div_s next_st;
  logic feed_and;
  logic rise;
  logic window;

  always_comb begin
    next_st = st;
    // Feedback AND: pulse reaches the 384k toggle on two of three master pulses
    feed_and = tif.master_gated && (st.div3 != DIV3_LAST);
    rise = tif.master_gated && (st.div3 == DIV3_RISE);
    // Window sampled before this edge moves the phases
    window = (st.frame_cnt == FRAME_HIGH) && st.phase_48k
             && st.phase_192k && st.phase_96k;
    next_st.rise384 = rise;
    next_st.pass_hit = rise && window;
    if (tif.master_gated) begin
      next_st.sq576 = ~st.sq576;
      next_st.div3 = (st.div3 == DIV3_LAST) ? 2'h0 : st.div3 + 2'h1;
    end
    if (feed_and) begin
      next_st.clk384 = ~st.clk384;
    end
    if (rise) begin
      next_st.phase_192k = ~st.phase_192k;
      if (!st.phase_192k) begin
        next_st.phase_96k = ~st.phase_96k;
        if (!st.phase_96k) begin
          next_st.phase_48k = ~st.phase_48k;
          if (!st.phase_48k) begin
            // Frame phase spans one whole 48k cycle, 20.8 us
            next_st.frame_cnt = (st.frame_cnt == FRAME_LAST) ? 3'h0
                                : st.frame_cnt + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= DIV_RESET;
    end else if (tif.clk_en) begin
      st <= next_st;
    end
  end

  assign tif.sq576 = st.sq576;
  assign tif.clk384 = st.clk384;
  assign tif.rise384 = st.rise384;
  assign tif.pass_hit = st.pass_hit;
  assign tif.phase_192k = st.phase_192k;
  assign tif.phase_96k = st.phase_96k;
  assign tif.phase_48k = st.phase_48k;
  assign tif.frame_phase_8k = (st.frame_cnt == FRAME_HIGH);
endmodule : rsft_divider

// ===== hdl/rsft_top.sv
/*
 * Receive frame skip timing: skip and search flags, master pulse gating,
 * frame trigger and address digit gate, all outputs registered.
 * Assumes MASTER_PULSE and SKIP_PULSE are one-cycle pulses synchronous
 * to CORE_CLK, and that the address comparison logic keeps sending skip
 * pulses only while timing and received address disagree.
 */
`timescale 1ns/1ps
module rsft_top (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic MASTER_PULSE,
  input wire logic SKIP_PULSE,
  input wire logic OUT_OF_FRAME,
  output logic FRAME_TRIGGER,
  output logic ADDR_DIGIT_GATE,
  output logic SEARCH_IND,
  output logic SQ_576K,
  output logic SQ_576K_N,
  output logic CLK_384K,
  output logic SHAPED_384K,
  output logic PHASE_192K,
  output logic PHASE_96K,
  output logic PHASE_48K,
  output logic FRAME_PHASE_8K,
  output logic DIVIDER_PULSE
);
  import rsft_pkg::*;

  typedef struct packed {
    logic skip_flag;
    logic search_flag;
    logic frame_trigger;
    logic addr_gate;
    logic sq576;
    logic sq576_n;
    logic clk384;
    logic shaped384;
    logic phase_192k;
    logic phase_96k;
    logic phase_48k;
    logic frame_phase_8k;
    logic divider_pulse;
  } rsft_top_s;

  localparam rsft_top_s TOP_RESET = '{sq576_n: 1'b1, default: 1'b0};

  rsft_timing_if tif ();

  rsft_top_s st;
  rsft_top_s next_st;
  logic master_gated;

  // Blanked while a skip is pending or the receiver is out of frame
  assign master_gated = MASTER_PULSE && !st.skip_flag && !OUT_OF_FRAME;
  assign tif.master_gated = master_gated;
  assign tif.clk_en = CLK_EN;

  rsft_divider u_divider (
    .core_clk(CORE_CLK),
    .rstn(RSTN),
    .tif(tif)
  );

  always_comb begin
    next_st = st;
    // Flag is consumed by the master pulse it blanks; one pulse lost per skip
    if (MASTER_PULSE) begin
      next_st.skip_flag = 1'b0;
      next_st.search_flag = 1'b0;
    end
    // Set wins over clear so a skip coinciding with a master pulse is kept
    if (SKIP_PULSE) begin
      next_st.skip_flag = 1'b1;
      next_st.search_flag = 1'b1;
    end
    next_st.frame_trigger = tif.pass_hit;
    next_st.addr_gate = tif.frame_phase_8k && tif.phase_48k;
    next_st.sq576 = tif.sq576;
    next_st.sq576_n = ~tif.sq576;
    next_st.clk384 = tif.clk384;
    next_st.shaped384 = tif.rise384;
    next_st.phase_192k = tif.phase_192k;
    next_st.phase_96k = tif.phase_96k;
    next_st.phase_48k = tif.phase_48k;
    next_st.frame_phase_8k = tif.frame_phase_8k;
    next_st.divider_pulse = master_gated;
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= TOP_RESET;
    end else if (CLK_EN) begin
      st <= next_st;
    end
  end

  assign FRAME_TRIGGER = st.frame_trigger;
  assign ADDR_DIGIT_GATE = st.addr_gate;
  assign SEARCH_IND = st.search_flag;
  assign SQ_576K = st.sq576;
  assign SQ_576K_N = st.sq576_n;
  assign CLK_384K = st.clk384;
  assign SHAPED_384K = st.shaped384;
  assign PHASE_192K = st.phase_192k;
  assign PHASE_96K = st.phase_96k;
  assign PHASE_48K = st.phase_48k;
  assign FRAME_PHASE_8K = st.frame_phase_8k;
  assign DIVIDER_PULSE = st.divider_pulse;
endmodule : rsft_top

// ===== verification/rsft_top_monitor.sv
/* Port checker for rsft_top.
 * Assumes one clock domain; bound to every rsft_top below. */
`timescale 1ns/1ps
module rsft_top_monitor (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic MASTER_PULSE,
  input wire logic SKIP_PULSE,
  input wire logic OUT_OF_FRAME,
  input wire logic FRAME_TRIGGER,
  input wire logic ADDR_DIGIT_GATE,
  input wire logic SEARCH_IND,
  input wire logic SQ_576K,
  input wire logic SQ_576K_N,
  input wire logic CLK_384K,
  input wire logic SHAPED_384K,
  input wire logic PHASE_192K,
  input wire logic PHASE_96K,
  input wire logic PHASE_48K,
  input wire logic FRAME_PHASE_8K,
  input wire logic DIVIDER_PULSE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic [5:0] n;
  logic seen;
  logic win_q;
  // First trigger after reset has a short frame, so it is not counted
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      n <= '0;
      seen <= 1'b0;
      win_q <= 1'b0;
    end else if (CLK_EN) begin
      // Frozen cycles hold every output, so they must not count
      win_q <= PHASE_192K && PHASE_96K && PHASE_48K && FRAME_PHASE_8K;
      if (FRAME_TRIGGER) begin
        n <= '0;
        seen <= 1'b1;
      end else if (SHAPED_384K) begin
        n <= n + 6'h01;
      end
    end
  end
  sequence s_mst;
    CLK_EN && MASTER_PULSE;
  endsequence
  chk_search_set: assert property (CLK_EN && SKIP_PULSE |=> SEARCH_IND)
    else $error("search flag not set by skip");
  chk_search_clear: assert property (s_mst ##0 !SKIP_PULSE |=> !SEARCH_IND)
    else $error("search flag not cleared by master");
  chk_skip_blank: assert property (SEARCH_IND ##0 s_mst |=> !DIVIDER_PULSE)
    else $error("master passed while skip pending");
  chk_oof_blank: assert property (OUT_OF_FRAME ##0 s_mst |=> !DIVIDER_PULSE)
    else $error("master passed out of frame");
  chk_master_pass: assert property (!SEARCH_IND && !OUT_OF_FRAME ##0 s_mst |=> DIVIDER_PULSE)
    else $error("clean master not passed");
  chk_div_cause: assert property (DIVIDER_PULSE && $past(CLK_EN) |-> $past(MASTER_PULSE))
    else $error("divider pulse without master");
  chk_sq_compl: assert property (SQ_576K != SQ_576K_N)
    else $error("576k pair not complementary");
  chk_sq_toggle: assert property (DIVIDER_PULSE && CLK_EN |=> SQ_576K != $past(SQ_576K))
    else $error("576k did not toggle");
  chk_trig_win: assert property (FRAME_TRIGGER |-> SHAPED_384K && win_q)
    else $error("trigger outside window");
  chk_trig_count: assert property (FRAME_TRIGGER && seen |-> n == 6'h2F)
    else $error("trigger not every 48th pulse");
  chk_gate_and: assert property (ADDR_DIGIT_GATE == (FRAME_PHASE_8K && PHASE_48K))
    else $error("address gate not frame AND 48k");
  chk_clk384_rise: assert property (SHAPED_384K && $past(CLK_EN) |-> $rose(CLK_384K))
    else $error("shaped pulse without 384k rise");
endmodule : rsft_top_monitor
bind rsft_top rsft_top_monitor u_rsft_top_monitor (.*);

// ===== verification/rsft_skip_src.sv
/* Address comparison model issuing skip pulses.
 * Assumes hunt is held high by the bench while out of coincidence. */
`timescale 1ns/1ps
module rsft_skip_src (
  input wire logic clk,
  input wire logic hunt,
  input wire logic master,
  output logic skip
);
  logic seen = 1'b0;
  initial skip = 1'b0;
  // Hunt taken on the rising edge, clear of the bench's falling-edge writes
  always @(posedge clk) seen <= master && hunt;
  // One skip after each master, only while hunting
  always @(negedge clk) skip <= seen;
endmodule : rsft_skip_src

// ===== verification/tb.sv
/* Self-checking bench for rsft_top.
 * Assumes master pulses every MP cycles, inputs driven on falling edges. */
`timescale 1ns/1ps
module tb;
  // Shortened master spacing keeps a frame near 1200 cycles
  localparam int MP = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mst = 1'b0;
  logic oof = 1'b0;
  logic hunt = 1'b0;
  logic en = 1'b1;
  logic skip, trig, gate, srch, sq, sqn, dpl;
  int err_count = 0;
  int cmp_count = 0;
  int ph = 0;
  always #2 clk = ~clk;
  always @(negedge clk) begin
    ph = (ph + 1) % MP;
    mst = (ph == 0);
  end
  rsft_top u_rsft_top (.CORE_CLK(clk), .RSTN(rstn), .CLK_EN(en), .MASTER_PULSE(mst),
    .SKIP_PULSE(skip), .OUT_OF_FRAME(oof), .FRAME_TRIGGER(trig), .ADDR_DIGIT_GATE(gate),
    .SEARCH_IND(srch), .SQ_576K(sq), .SQ_576K_N(sqn), .CLK_384K(), .SHAPED_384K(),
    .PHASE_192K(), .PHASE_96K(), .PHASE_48K(), .FRAME_PHASE_8K(), .DIVIDER_PULSE(dpl));
  rsft_skip_src u_rsft_skip_src (.clk(clk), .hunt(hunt), .master(mst), .skip(skip));
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk
  task wtrig(output int t);
    int c;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (trig !== 1'b1 && c < 3000);
    t = int'($time);
  endtask : wtrig
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task t_frame;
    int a, b;
    wtrig(a);
    wtrig(b);
    chk(b - a, 4 * MP * 144, "frame period");
  endtask : t_frame
  // Gate spans four shaped 384k pulses, three master pulses each
  task t_gate;
    int c;
    c = 0;
    @(negedge clk iff gate === 1'b0);
    @(negedge clk iff gate === 1'b1);
    while (gate === 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
    chk(c, 12 * MP, "address gate width");
  endtask : t_gate
  task t_skip;
    int a, b;
    wtrig(a);
    @(negedge clk) hunt = 1'b1;
    @(posedge clk iff skip);
    @(negedge clk) chk(srch, 1, "search set");
    @(posedge clk iff mst);
    @(negedge clk) chk(srch, 0, "search clear");
    repeat (2) @(posedge clk iff skip);
    @(negedge clk) hunt = 1'b0;
    wtrig(b);
    chk(b - a, 4 * MP * 147, "slipped frame");
  endtask : t_skip
  task t_oof;
    int a, b;
    wtrig(a);
    @(negedge clk) oof = 1'b1;
    repeat (4 * MP) @(negedge clk);
    oof = 1'b0;
    wtrig(b);
    chk(b - a, 4 * MP * 148, "withheld frame");
  endtask : t_oof
  // Enable low: outputs hold and the master pulses in the gap are lost
  task t_hold;
    int a, b;
    logic [5:0] held;
    wtrig(a);
    @(negedge clk) en = 1'b0;
    held = {sq, sqn, srch, trig, gate, dpl};
    repeat (4 * MP) @(negedge clk);
    chk({sq, sqn, srch, trig, gate, dpl}, held, "frozen outputs");
    en = 1'b1;
    wtrig(b);
    chk(b - a, 4 * MP * 148, "frozen frame");
  endtask : t_hold
  initial begin
    repeat (5) @(negedge clk);
    chk({sq, sqn, srch, trig, gate, dpl}, 16'h0010, "reset outputs");
    rstn = 1'b1;
    t_frame;
    t_gate;
    t_skip;
    t_oof;
    t_hold;
    give_verdict;
  end
  // About twice the expected run of some ten thousand cycles
  initial begin
    #80000;
    err_count++;
    give_verdict;
  end
endmodule : tb
